// ---- rtl/scps_pkg.sv ----
package scps_pkg;

  // ****************************************************************
  // slave address and first-byte layout
  // ****************************************************************
  localparam logic [5:0] ADDR_FIXED_BITS = 6'h10; // byte bits 7:2 of 0x40..0x43
  localparam int SEL_BIT_POS = 1; // follows address_select_pin
  localparam int RW_BIT_POS = 0; // 1 = master reads
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // ****************************************************************
  // subaddress space
  // ****************************************************************
  localparam int NUM_SUBADDR = 196;
  localparam logic [7:0] SUBADDR_HIGHEST = 8'(NUM_SUBADDR - 1);
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] READ_BLOCKED_DATA = 8'h00;
  localparam logic [7:0] RO_LO_A = 8'h10;
  localparam logic [7:0] RO_HI_A = 8'h13;
  localparam logic [7:0] RO_LO_B = 8'h91;
  localparam logic [7:0] RO_HI_B = 8'h9d;
  localparam logic [7:0] WO_A = 8'h8f;
  localparam logic [7:0] WO_B = 8'hb2;

  // ****************************************************************
  // multi-register parameter (horizontal sync begin)
  // ****************************************************************
  localparam logic [7:0] SEQ_FIRST_ADDR = 8'h34;
  localparam logic [7:0] SEQ_LAST_ADDR = 8'h35;
  localparam logic [15:0] SEQ_PARAM_RESET = 16'h0002;

  // ****************************************************************
  // protocol states
  // ****************************************************************
  typedef enum logic [3:0] {
    SCPS_IDLE = 4'b0000,
    SCPS_ADDR = 4'b0001,
    SCPS_ADDR_ACK = 4'b0010,
    SCPS_PTR = 4'b0011,
    SCPS_PTR_ACK = 4'b0100,
    SCPS_WR_DATA = 4'b0101,
    SCPS_WR_ACK = 4'b0110,
    SCPS_RD_DATA = 4'b0111,
    SCPS_RD_ACK = 4'b1000
  } scps_state_t;

  // registers that only report state
  function automatic logic scps_is_read_only(input logic [7:0] a);
    return ((a >= RO_LO_A) && (a <= RO_HI_A)) || ((a >= RO_LO_B) && (a <= RO_HI_B));
  endfunction

  // registers that only take settings
  function automatic logic scps_is_write_only(input logic [7:0] a);
    return (a == WO_A) || (a == WO_B);
  endfunction

endpackage

// ---- rtl/scps_sequencer.sv ----
`timescale 1ns/1ns
module scps_sequencer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic [15:0] param_q,
  output logic param_commit
);

  // ****************************************************************
  // shadow of the first part, applied with the last part
  // ****************************************************************
  logic [7:0] hold_ff;
  logic [7:0] nxt_hold;
  logic pend_ff;
  logic nxt_pend;
  logic [15:0] param_ff;
  logic [15:0] nxt_param;
  logic commit_ff;
  logic nxt_commit;

  // next-value logic for shadow and applied value
  always_comb begin
    nxt_hold = hold_ff;
    nxt_pend = pend_ff;
    nxt_param = param_ff;
    nxt_commit = 1'b0;
    if (wr_stb) begin
      if (wr_addr == scps_pkg::SEQ_FIRST_ADDR) begin
        nxt_hold = wr_data;
        nxt_pend = 1'b1;
      end else if (wr_addr == scps_pkg::SEQ_LAST_ADDR) begin
        nxt_param = {(pend_ff ? hold_ff : param_ff[15:8]), wr_data};
        nxt_pend = 1'b0;
        nxt_commit = 1'b1;
      end else begin
        nxt_pend = 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_ff <= 8'h00;
      pend_ff <= 1'b0;
      param_ff <= scps_pkg::SEQ_PARAM_RESET;
      commit_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      param_ff <= nxt_param;
      commit_ff <= nxt_commit;
    end
  end

  assign param_q = param_ff;
  assign param_commit = commit_ff;

endmodule

// ---- rtl/scps_serial_port.sv ----
`timescale 1ns/1ns
// Behaviour
// - answer 0x40/0x42 family, bit1 from select pin
// - first byte bit0 one means master reads
// - start is data falling while clock high
// - address plus direction, bytes msb first
// - matched address acknowledged on ninth pulse
// - mismatch releases bus, keep watching starts
// - second byte loads register pointer
// - pointer advances after every data byte, holding at the highest register on reads
// - stop anywhere returns to idle, start anywhere restarts address phase
// - invalid pointer byte gets no acknowledge
// - read past top repeats highest register
// - write past top: drop, no acknowledge, idle
// - read-only not written, write-only not read
// - wide parameter applied after last part
module scps_serial_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_en,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  output logic [15:0] horizontal_sync_begin_param,
  output logic horizontal_sync_begin_commit,
  output logic busy
);

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] sel_sync_ff;
  logic scl_dly_ff;
  logic sda_dly_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // two flops per pin, plus one delayed copy for edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sel_sync_ff <= 2'h0;
      scl_dly_ff <= 1'b1;
      sda_dly_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      sel_sync_ff <= {sel_sync_ff[0], address_select_pin};
      scl_dly_ff <= scl_sync_ff[1];
      sda_dly_ff <= sda_sync_ff[1];
    end
  end

  assign scl_rise = scl_sync_ff[1] & ~scl_dly_ff;
  assign scl_fall = ~scl_sync_ff[1] & scl_dly_ff;
  assign start_det = scl_sync_ff[1] & scl_dly_ff & sda_dly_ff & ~sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] & scl_dly_ff & ~sda_dly_ff & sda_sync_ff[1];

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  scps_pkg::scps_state_t state_ff;
  scps_pkg::scps_state_t nxt_state;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [2:0] bit_cnt_ff;
  logic [2:0] nxt_bit_cnt;
  logic got8_ff;
  logic nxt_got8;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic read_ff;
  logic nxt_read;
  logic nack_ff;
  logic nxt_nack;
  logic oe_ff;
  logic nxt_oe;
  logic wr_en_ff;
  logic nxt_wr_en;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_wr_data;
  logic rd_fetch;
  logic [7:0] rd_byte;
  logic addr_match;

  // first byte: fixed bits, select bit from pin
  assign addr_match = (shift_ff[7:2] == scps_pkg::ADDR_FIXED_BITS) &&
                      (shift_ff[scps_pkg::SEL_BIT_POS] == sel_sync_ff[1]);

  // data offered to the master, write-only registers read as zero
  assign rd_byte = scps_pkg::scps_is_write_only(ptr_ff) ? scps_pkg::READ_BLOCKED_DATA
                                                        : reg_rd_data;

  // next-state logic for the whole transfer
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_got8 = got8_ff;
    nxt_ptr = ptr_ff;
    nxt_read = read_ff;
    nxt_nack = nack_ff;
    nxt_wr_en = 1'b0;
    nxt_wr_data = wr_data_ff;
    rd_fetch = 1'b0;
    if (stop_det) begin
      nxt_state = scps_pkg::SCPS_IDLE;
    end else if (start_det) begin
      nxt_state = scps_pkg::SCPS_ADDR;
      nxt_bit_cnt = 3'h0;
      nxt_got8 = 1'b0;
    end else begin
      case (state_ff)
        scps_pkg::SCPS_IDLE: begin
          nxt_got8 = 1'b0;
        end
        scps_pkg::SCPS_ADDR, scps_pkg::SCPS_PTR, scps_pkg::SCPS_WR_DATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_sync_ff[1]};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            nxt_got8 = (bit_cnt_ff == scps_pkg::BIT_CNT_LAST);
          end else if (scl_fall && got8_ff) begin
            nxt_got8 = 1'b0;
            if (state_ff == scps_pkg::SCPS_ADDR) begin
              if (addr_match) begin
                nxt_state = scps_pkg::SCPS_ADDR_ACK;
                nxt_read = shift_ff[scps_pkg::RW_BIT_POS];
              end else begin
                nxt_state = scps_pkg::SCPS_IDLE;
              end
            end else if (state_ff == scps_pkg::SCPS_PTR) begin
              if (shift_ff <= scps_pkg::SUBADDR_HIGHEST) begin
                nxt_ptr = shift_ff;
                nxt_state = scps_pkg::SCPS_PTR_ACK;
              end else begin
                nxt_state = scps_pkg::SCPS_IDLE;
              end
            end else if (ptr_ff > scps_pkg::SUBADDR_HIGHEST) begin
              nxt_state = scps_pkg::SCPS_IDLE;
              nxt_ptr = scps_pkg::SUBADDR_HIGHEST;
            end else begin
              nxt_wr_en = ~scps_pkg::scps_is_read_only(ptr_ff);
              nxt_wr_data = shift_ff;
              nxt_state = scps_pkg::SCPS_WR_ACK;
            end
          end
        end
        scps_pkg::SCPS_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 3'h0;
            if (read_ff) begin
              rd_fetch = 1'b1;
              nxt_state = scps_pkg::SCPS_RD_DATA;
            end else begin
              nxt_state = scps_pkg::SCPS_PTR;
            end
          end
        end
        scps_pkg::SCPS_PTR_ACK, scps_pkg::SCPS_WR_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 3'h0;
            nxt_state = scps_pkg::SCPS_WR_DATA;
            if (state_ff == scps_pkg::SCPS_WR_ACK) begin
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        scps_pkg::SCPS_RD_DATA: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            nxt_got8 = (bit_cnt_ff == scps_pkg::BIT_CNT_LAST);
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b1};
            if (got8_ff) begin
              nxt_got8 = 1'b0;
              nxt_state = scps_pkg::SCPS_RD_ACK;
            end
          end
        end
        scps_pkg::SCPS_RD_ACK: begin
          if (scl_rise) begin
            nxt_nack = sda_sync_ff[1];
          end else if (scl_fall) begin
            nxt_bit_cnt = 3'h0;
            if (nack_ff) begin
              nxt_state = scps_pkg::SCPS_IDLE;
            end else begin
              rd_fetch = 1'b1;
              nxt_state = scps_pkg::SCPS_RD_DATA;
            end
          end
        end
        default: begin
          nxt_state = scps_pkg::SCPS_IDLE;
        end
      endcase
    end
    if (rd_fetch) begin
      nxt_shift = rd_byte;
      if (ptr_ff < scps_pkg::SUBADDR_HIGHEST) begin
        nxt_ptr = ptr_ff + 8'h01;
      end else begin
        nxt_ptr = scps_pkg::SUBADDR_HIGHEST;
      end
    end
    // pull low for acks, and for zero bits of read data
    case (nxt_state)
      scps_pkg::SCPS_ADDR_ACK, scps_pkg::SCPS_PTR_ACK, scps_pkg::SCPS_WR_ACK: begin
        nxt_oe = 1'b1;
      end
      scps_pkg::SCPS_RD_DATA: begin
        nxt_oe = ~nxt_shift[7];
      end
      default: begin
        nxt_oe = 1'b0;
      end
    endcase
  end

  // registers of the protocol engine
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= scps_pkg::SCPS_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      got8_ff <= 1'b0;
      ptr_ff <= scps_pkg::POINTER_RESET;
      read_ff <= 1'b0;
      nack_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      got8_ff <= nxt_got8;
      ptr_ff <= nxt_ptr;
      read_ff <= nxt_read;
      nack_ff <= nxt_nack;
      oe_ff <= nxt_oe;
      wr_en_ff <= nxt_wr_en;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // ****************************************************************
  // outputs and wide-parameter sequencer
  // ****************************************************************
  logic [7:0] wr_addr_ff;

  // address of the byte just written, held for the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_addr_ff <= 8'h00;
    end else if (nxt_wr_en) begin
      wr_addr_ff <= ptr_ff;
    end
  end

  assign sda_out = 1'b0; // open drain, only ever pulls low
  assign sda_oe = oe_ff;
  assign reg_addr = reg_wr_en ? wr_addr_ff : ptr_ff;
  assign reg_wr_data = wr_data_ff;
  assign reg_wr_en = wr_en_ff;
  assign reg_rd_en = rd_fetch & ~scps_pkg::scps_is_write_only(ptr_ff);
  assign busy = (state_ff != scps_pkg::SCPS_IDLE);

  scps_sequencer u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_stb(wr_en_ff),
    .wr_addr(wr_addr_ff),
    .wr_data(wr_data_ff),
    .param_q(horizontal_sync_begin_param),
    .param_commit(horizontal_sync_begin_commit)
  );

endmodule

// ---- testbench/scps_serial_port_props.sv ----
`timescale 1ns/1ns
module scps_serial_port_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] horizontal_sync_begin_param,
  input wire logic horizontal_sync_begin_commit,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // bus framing and pin drive
  // ****************************************************************
  property p_start_busy;
    $fell(sda_in) && scl_in |-> ##[1:6] busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("no busy after start");
  property p_stop_idle;
    $rose(sda_in) && scl_in |-> ##[1:6] !busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no idle after stop");
  property p_idle_quiet;
    !busy && !$past(busy) |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data pulled while idle");
  property p_oe_low;
    !$stable(sda_oe) |-> !scl_in;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("data drive moved with clock high");

  // ****************************************************************
  // register side
  // ****************************************************************
  property p_wr_ro;
    reg_wr_en |-> !(reg_addr inside {[8'h10:8'h13], [8'h91:8'h9d]});
  endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("write to read-only register");
  property p_rd_wo;
    reg_rd_en |-> !(reg_addr inside {8'h8f, 8'hb2});
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("fetch of write-only register");
  property p_wr_top;
    reg_wr_en |-> reg_addr <= 8'hc3;
  endproperty
  a_wr_top: assert property (p_wr_top) else $error("write above highest register");
  property p_commit;
    horizontal_sync_begin_commit |-> $past(reg_wr_en) && $past(reg_addr) == 8'h35
      && horizontal_sync_begin_param[7:0] == $past(reg_wr_data);
  endproperty
  a_commit: assert property (p_commit) else $error("commit without last part write");
  property p_param_hold;
    !$stable(horizontal_sync_begin_param) |-> horizontal_sync_begin_commit;
  endproperty
  a_param_hold: assert property (p_param_hold) else $error("parameter moved alone");

  c_commit: cover property (horizontal_sync_begin_commit);
  c_read: cover property (reg_rd_en);
  c_ack: cover property (sda_oe && scl_in);
endmodule

bind scps_serial_port scps_serial_port_chk u_chk (.core_clk, .rst_n, .scl_in, .sda_in,
  .sda_oe, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .horizontal_sync_begin_param,
  .horizontal_sync_begin_commit, .busy);

// ---- testbench/scps_bus_master.sv ----
`timescale 1ns/1ns
module scps_bus_master (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // ****************************************************************
  // two-wire master, 800 ns bit, clock still between frames
  // ****************************************************************
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // wait n falling core edges
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // start or repeated start, one condition per high phase
  task automatic start();
    w(2);
    sda_drv = 1'b1;
    w(3);
    scl = 1'b1;
    w(3);
    sda_drv = 1'b0;
    w(3);
    scl = 1'b0;
  endtask
  // stop, then bus left idle
  task automatic stop();
    w(2);
    sda_drv = 1'b0;
    w(3);
    scl = 1'b1;
    w(3);
    sda_drv = 1'b1;
    w(8);
  endtask
  // one bit: data moves in low phase, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_drv = b;
    w(3);
    scl = 1'b1;
    w(3);
    r = sda;
    scl = 1'b0;
  endtask
  // one byte msb first plus ninth bit
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r,
    output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], x);
      r[i] = x;
    end
    bit_io(mack, ack);
  endtask
endmodule

// ---- testbench/serial_control_port_slave_tb.sv ----
`timescale 1ns/1ns
module serial_control_port_slave_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic [7:0] reg_addr;
  logic [7:0] reg_wr_data;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [7:0] reg_rd_data;
  logic [15:0] param;
  logic commit;
  logic busy;
  logic [7:0] mem [256];
  int err_count = 0;
  int num_checks = 0;
  // pulled-up data wire
  wire sda = sda_drv & (sda_oe ? sda_out : 1'b1);

  // ****************************************************************
  // clock, register store, instances
  // ****************************************************************
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  assign reg_rd_data = mem[reg_addr];
  // register store takes design writes
  always @(posedge core_clk) begin
    if (reg_wr_en === 1'b1) begin
      mem[reg_addr] <= reg_wr_data;
    end
  end
  scps_serial_port dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(sel), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .horizontal_sync_begin_param(param),
    .horizontal_sync_begin_commit(commit), .busy(busy));
  scps_bus_master mst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] iv(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // pointer then data bytes, first nok acknowledged
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$], input int nok);
    logic [7:0] r;
    logic a;
    mst.start();
    mst.byte_io(8'h40, 1'b1, r, a);
    chk(16'(a), 16'h0000);
    mst.byte_io(ptr, 1'b1, r, a);
    chk(16'(a), 16'(ptr > 8'hc3));
    foreach (d[i]) begin
      mst.byte_io(d[i], 1'b1, r, a);
      chk(16'(a), 16'(i >= nok));
    end
    mst.stop();
  endtask
  // set pointer, repeated start, read until no acknowledge
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
    logic [7:0] r;
    logic a;
    mst.start();
    mst.byte_io(8'h40, 1'b1, r, a);
    mst.byte_io(ptr, 1'b1, r, a);
    mst.start();
    mst.byte_io(8'h41, 1'b1, r, a);
    chk(16'(a), 16'h0000);
    foreach (e[i]) begin
      mst.byte_io(8'hff, i == e.size() - 1, r, a);
      chk(16'(r), 16'(e[i]));
    end
    mst.stop();
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] r;
    logic a;
    for (int i = 0; i < 256; i++) begin
      mem[i] <= iv(8'(i));
    end
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(param, scps_pkg::SEQ_PARAM_RESET);
    chk(16'(busy), 16'h0000);
    for (int s = 0; s < 4; s++) begin
      sel = s[1];
      mst.start();
      mst.byte_io({6'h10, s[0], 1'b0}, 1'b1, r, a);
      chk(16'(a), 16'(s[0] != s[1]));
      mst.stop();
    end
    sel = 1'b0;
    wr(8'h20, {8'ha5, 8'h3c}, 2);
    rd(8'h20, {8'ha5, 8'h3c, iv(8'h22)});
    wr(8'hc4, {8'h00}, 0);
    wr(8'hc3, {8'h11, 8'h22}, 1);
    chk(16'(mem[8'hc4]), 16'(iv(8'hc4)));
    rd(8'hc2, {iv(8'hc2), 8'h11, 8'h11});
    wr(8'h10, {8'h77}, 1);
    chk(16'(mem[8'h10]), 16'(iv(8'h10)));
    rd(8'h8f, {scps_pkg::READ_BLOCKED_DATA});
    wr(8'h34, {8'h01}, 1);
    chk(param, scps_pkg::SEQ_PARAM_RESET);
    wr(8'h35, {8'h23}, 1);
    chk(param, 16'h0123);
    wr(8'h34, {8'h45}, 1);
    wr(8'h21, {8'h3c}, 1);
    wr(8'h35, {8'h67}, 1);
    chk(param, 16'h0167);
    mst.start();
    mst.byte_io(8'h40, 1'b1, r, a);
    mst.byte_io(8'h30, 1'b1, r, a);
    repeat (4) mst.bit_io(1'b0, a);
    mst.stop();
    chk(16'(mem[8'h30]), 16'(iv(8'h30)));
    chk(16'(busy), 16'h0000);
    stop_test();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
endmodule
